// File: src/sar_adc_host_interface.sv
`timescale 1ns/10ps
`include "sar_adc_regs.svh"

// How it works
// - cs low, busy high: r/c fall starts
// - cs low: r/c rise drives parallel bus
// - r/c low: cs fall starts conversion
// - internal clock mode: same edge starts serial
// - busy low until result fully updated
// - byte select picks high or low byte
// - bus released when cs high or r/c low
// - shift clock driven only in internal mode
// - serial bit changes with shift clock
// - tag input used only in external mode
// - format select: binary or two's complement
// - analog shutdown leaves digital logic active
// - reference shutdown disables internal reference
// - starts while busy low begin no conversion, but in internal mode still queue a serial send
// - sixteen bits, msb first, stable at rising edges
module sar_adc_host_interface #(
    parameter int CONVERT_CYCLES = 64,
    parameter int SHIFT_DIV      = 4
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        chip_select_n,
    input  wire logic        read_convert,
    input  wire logic        byte_select,
    input  wire logic        result_format_select,
    input  wire logic        clock_source_select,
    input  wire logic        analog_shutdown,
    input  wire logic        reference_shutdown,
    input  wire logic [15:0] sample_code,
    output logic             sample_hold,
    output logic             analog_power_on,
    output logic             reference_enable,
    output logic             busy_n,
    output logic      [7:0]  parallel_data_out,
    output logic      [7:0]  parallel_data_oe,
    input  wire logic        serial_shift_clock_in,
    output logic             serial_shift_clock_out,
    output logic             serial_shift_clock_oe,
    output logic             serial_result_out,
    input  wire logic        tag_in
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [6:0] sync1;
    logic [6:0] sync2;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 7'h7f;
            sync2 <= 7'h7f;
        end else begin
            sync1 <= {chip_select_n, read_convert, byte_select, result_format_select,
                      clock_source_select, analog_shutdown, reference_shutdown};
            sync2 <= sync1;
        end
    end

    logic cs_n_s;
    logic rc_s;
    logic byte_s;
    logic fmt_s;
    logic ext_s;
    logic analog_shutdown_s;
    logic reference_shutdown_s;
    assign {cs_n_s, rc_s, byte_s, fmt_s, ext_s, analog_shutdown_s, reference_shutdown_s} = sync2;

    // ------------------------------------------------------------
    // start detection
    // ------------------------------------------------------------
    // internally or'ed: a start is the combined level falling after
    // a filter of START_LOW_CYCLES samples, so glitches never start
    logic       comb_high;
    logic       armed;
    logic [4:0] low_count;
    logic       start_req;
    assign comb_high = cs_n_s | rc_s;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            armed     <= 1'b0;
            low_count <= '0;
        end else if (comb_high) begin
            armed     <= 1'b1;
            low_count <= '0;
        end else if (armed && low_count != 5'(`START_LOW_CYCLES)) begin
            low_count <= low_count + 5'd1;
        end else begin
            armed     <= 1'b0;
        end
    end

    // one start per low period; held low across busy high, no restart
    assign start_req = !comb_high && armed && (low_count == 5'(`START_LOW_CYCLES) - 5'd1);

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    sar_adc_pkg::conv_state_t state;
    logic [15:0] conv_count;
    logic [15:0] result;
    logic        serial_go;
    logic        serial_active;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state      <= sar_adc_pkg::CONV_IDLE;
            conv_count <= '0;
        end else begin
            case (state)
                sar_adc_pkg::CONV_IDLE: begin
                    if (start_req) begin
                        state      <= sar_adc_pkg::CONV_RUN;
                        conv_count <= '0;
                    end
                end
                sar_adc_pkg::CONV_RUN: begin
                    if (conv_count == 16'(CONVERT_CYCLES - 1)) begin
                        state <= sar_adc_pkg::CONV_DONE;
                    end else begin
                        conv_count <= conv_count + 16'd1;
                    end
                end
                sar_adc_pkg::CONV_DONE: begin
                    if (!serial_active) begin
                        state <= sar_adc_pkg::CONV_IDLE;
                    end
                end
                default: state <= sar_adc_pkg::CONV_IDLE;
            endcase
        end
    end

    assign busy_n      = (state == sar_adc_pkg::CONV_IDLE);
    assign sample_hold = !busy_n;
    assign analog_power_on  = !analog_shutdown_s;
    assign reference_enable = !reference_shutdown_s;

    // ------------------------------------------------------------
    // result register and formatting
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            result <= `RESULT_RESET;
        end else if (state == sar_adc_pkg::CONV_RUN
                     && conv_count == 16'(CONVERT_CYCLES - 1)) begin
            result <= fmt_s ? sample_code : sample_code ^ `SIGN_FLIP;
        end
    end

    // ------------------------------------------------------------
    // parallel bus
    // ------------------------------------------------------------
    logic bus_on;
    assign bus_on = !cs_n_s && rc_s;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            parallel_data_out <= 8'h00;
            parallel_data_oe  <= 8'h00;
        end else begin
            parallel_data_out <= byte_s ? result[7:0] : result[15:8];
            parallel_data_oe  <= {8{bus_on}};
        end
    end

    // ------------------------------------------------------------
    // serial path: internal mode queues the previous result, external mode sends the new one
    // ------------------------------------------------------------
    // internal mode: start edge sends the previous result
    // result still holds the previous conversion at the start edge
    assign serial_go = start_req && !ext_s;

    logic        q_valid;
    logic        q_ready;
    logic [15:0] q_data;
    sar_result_fifo #(.WIDTH(16), .DEPTH(16)) u_fifo (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (serial_go),
        .in_ready  (),
        .in_data   (result),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    // internal divider makes the shift clock in the system domain
    logic [7:0]  div_count;
    logic        int_clk;
    logic        int_tick;
    logic [15:0] shreg;
    logic [4:0]  bits_left;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_count <= '0;
            int_clk   <= 1'b0;
        end else if (bits_left != '0 && !ext_s) begin
            if (div_count == 8'(SHIFT_DIV - 1)) begin
                div_count <= '0;
                int_clk   <= !int_clk;
            end else begin
                div_count <= div_count + 8'd1;
            end
        end else begin
            div_count <= '0;
            int_clk   <= 1'b0;
        end
    end
    assign int_tick = (div_count == 8'(SHIFT_DIV - 1)) && int_clk;

    assign q_ready = (bits_left == '0) && !ext_s;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            shreg     <= `RESULT_RESET;
            bits_left <= '0;
        end else if (q_valid && q_ready) begin
            shreg     <= q_data;
            bits_left <= `RESULT_BITS;
        end else if (int_tick) begin
            shreg     <= {shreg[14:0], 1'b0};
            bits_left <= bits_left - 5'd1;
        end
    end
    assign serial_shift_clock_out = int_clk;
    assign serial_shift_clock_oe  = !ext_s;

    // external mode: link domain shifts on host clock falling edges.
    // word and toggle only move as a conversion completes, while the host
    // keeps its clock still; a stopped clock cannot run a synchroniser,
    // so the link side reads them as quasi-static levels
    logic        ld_t;
    logic [15:0] ld_word;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ld_t    <= 1'b0;
            ld_word <= `RESULT_RESET;
        end else if (state == sar_adc_pkg::CONV_DONE && ext_s && !serial_active) begin
            ld_t    <= !ld_t;
            ld_word <= result;
        end
    end

    logic        lk_seen;
    logic        lk_fresh;
    logic [15:0] ext_sh;
    logic        tag_q;
    logic        ext_link_bit;
    // fresh word: msb is shown before the first host edge of the frame
    assign lk_fresh     = (ld_t != lk_seen);
    assign ext_link_bit = lk_fresh ? ld_word[15] : ext_sh[15];
    always_ff @(negedge serial_shift_clock_in or negedge arst_n) begin
        if (!arst_n) begin
            lk_seen <= 1'b0;
            ext_sh  <= `RESULT_RESET;
        end else if (lk_fresh) begin
            lk_seen <= ld_t;
            ext_sh  <= {ld_word[14:0], tag_q};
        end else begin
            ext_sh  <= {ext_sh[14:0], tag_q};
        end
    end
    always_ff @(posedge serial_shift_clock_in or negedge arst_n) begin
        if (!arst_n) begin
            tag_q <= 1'b0;
        end else begin
            tag_q <= tag_in;
        end
    end

    assign serial_active     = (bits_left != '0) || q_valid;
    assign serial_result_out = ext_s ? ext_link_bit : shreg[15];
endmodule : sar_adc_host_interface

// File: src/sar_adc_regs.svh
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLOCK_PERIOD_PS       32'd4000
`define START_LOW_MIN_PS      32'd40000
`define START_LOW_CYCLES      ((`START_LOW_MIN_PS + `CLOCK_PERIOD_PS - 32'd1) / `CLOCK_PERIOD_PS)
`define CONVERT_CYCLES_DEF    32'd64
`define INT_SHIFT_DIV_DEF     32'd4

// ------------------------------------------------------------
// result layout
// ------------------------------------------------------------
`define RESULT_MSB            4'd15
`define RESULT_BITS           5'd16
`define RESULT_RESET          16'h0000
`define SIGN_FLIP             16'h8000

`endif

// File: src/sar_adc_pkg.sv
package sar_adc_pkg;
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_DONE
    } conv_state_t;
endpackage : sar_adc_pkg

// File: src/sar_result_fifo.sv
`timescale 1ns/10ps
module sar_result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : sar_result_fifo

// File: test/sar_host_model.sv
`timescale 1ns/10ps
module sar_host_model (
    input  wire logic serial_result_out,
    output logic      serial_shift_clock_in,
    output logic      tag_in
);
    // ----------------
    // host shift clock
    // ----------------
    initial begin
        serial_shift_clock_in = 1'h0;
        tag_in                = 1'h0;
    end
    // clock stands low between frames, 125 ns period inside one
    task automatic read_frame(output logic [15:0] word);
        for (int i = 0; i < 16; i++) begin
            #62.5 serial_shift_clock_in = 1'h1;
            word = {word[14:0], serial_result_out};
            #62.5 serial_shift_clock_in = 1'h0;
            // tag moves after the fall, steady at the next rise
            tag_in = ~tag_in;
        end
    endtask : read_frame
endmodule : sar_host_model

// File: test/sar_adc_host_interface_properties.sv
`timescale 1ns/10ps
module sar_adc_host_interface_checker (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       chip_select_n,
    input wire logic       read_convert,
    input wire logic       byte_select,
    input wire logic       result_format_select,
    input wire logic       clock_source_select,
    input wire logic       analog_shutdown,
    input wire logic       reference_shutdown,
    input wire logic       analog_power_on,
    input wire logic       reference_enable,
    input wire logic       busy_n,
    input wire logic [7:0] parallel_data_out,
    input wire logic [7:0] parallel_data_oe,
    input wire logic       serial_shift_clock_oe
);
    // -------
    // helpers
    // -------
    logic       req_low;
    logic       armed;
    logic [4:0] low_cnt;
    logic [2:0] up_cnt;
    assign req_low = !(chip_select_n || read_convert);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt <= 5'h00;
            armed   <= 1'h0;
        end else begin
            low_cnt <= !req_low ? 5'h00 : low_cnt + {4'h0, low_cnt != 5'h1f};
            armed   <= !req_low ? busy_n : armed;
        end
    end
    // outputs from reset need a few edges before they track inputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            up_cnt <= 3'h0;
        end else begin
            up_cnt <= up_cnt + {2'h0, up_cnt != 3'h7};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ----------
    // properties
    // ----------
    property p_start;
        armed && low_cnt == 5'h0a |-> ##[1:6] !busy_n;
    endproperty
    a_start: assert property (p_start)
        else $error("busy_n missing after start");
    property p_oe_on;
        (up_cnt == 3'h7 && !chip_select_n && read_convert)[*5] |-> parallel_data_oe == 8'hff;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("parallel bus not driven");
    property p_oe_off;
        (up_cnt == 3'h7 && (chip_select_n || !read_convert))[*5] |-> parallel_data_oe == 8'h00;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("parallel bus not released");
    property p_busy_min;
        $fell(busy_n) |-> !busy_n[*8];
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("busy_n too short");
    property p_no_restart;
        $rose(busy_n) |-> busy_n[*3];
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("busy_n restarted at once");
    property p_out_hold;
        (busy_n && $stable(byte_select) && $stable(result_format_select))[*6]
            |=> $stable(parallel_data_out);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("parallel byte changed while idle");
    property p_clk_oe;
        (up_cnt == 3'h7 && $stable(clock_source_select))[*4]
            |-> serial_shift_clock_oe == !clock_source_select;
    endproperty
    a_clk_oe: assert property (p_clk_oe)
        else $error("shift clock enable wrong");
    property p_power;
        (up_cnt == 3'h7 && $stable(analog_shutdown))[*4] |-> analog_power_on == !analog_shutdown;
    endproperty
    a_power: assert property (p_power)
        else $error("analog power wrong");
    property p_ref;
        (up_cnt == 3'h7 && $stable(reference_shutdown))[*4]
            |-> reference_enable == !reference_shutdown;
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference enable wrong");
endmodule : sar_adc_host_interface_checker
bind sar_adc_host_interface sar_adc_host_interface_checker u_checker (.clock, .arst_n,
    .chip_select_n, .read_convert, .byte_select, .result_format_select, .clock_source_select,
    .analog_shutdown, .reference_shutdown, .analog_power_on, .reference_enable, .busy_n,
    .parallel_data_out, .parallel_data_oe, .serial_shift_clock_oe);

// File: test/sar_adc_host_interface_tb_top.sv
`timescale 1ns/10ps
module sar_adc_host_interface_tb_top;
    logic        clock, arst_n, chip_select_n, read_convert, byte_select;
    logic        result_format_select, clock_source_select, analog_shutdown;
    logic        reference_shutdown, sample_hold, analog_power_on, reference_enable;
    logic        busy_n, serial_shift_clock_out, serial_shift_clock_oe;
    logic        serial_result_out, tag_in, host_clk, shift_wire;
    logic [15:0] sample_code, last;
    logic [7:0]  parallel_data_out, parallel_data_oe;
    int          err_count = 0;
    int          comparisons = 0;
    // two-way shift clock pin
    assign shift_wire = serial_shift_clock_oe ? serial_shift_clock_out : host_clk;
    sar_adc_host_interface #(.CONVERT_CYCLES(32), .SHIFT_DIV(4)) u_dut (.clock, .arst_n,
        .chip_select_n, .read_convert, .byte_select, .result_format_select,
        .clock_source_select, .analog_shutdown, .reference_shutdown, .sample_code,
        .sample_hold, .analog_power_on, .reference_enable, .busy_n, .parallel_data_out,
        .parallel_data_oe, .serial_shift_clock_in(shift_wire), .serial_shift_clock_out,
        .serial_shift_clock_oe, .serial_result_out, .tag_in);
    sar_host_model u_host (.serial_result_out, .serial_shift_clock_in(host_clk), .tag_in);
    // -------
    // helpers
    // -------
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic start(logic via_cs);
        int n = 0;
        chip_select_n <= via_cs;
        read_convert  <= !via_cs;
        repeat (3) @(posedge clock);
        chip_select_n <= 1'h0;
        read_convert  <= 1'h0;
        while (busy_n !== 1'h0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        check("busy_n low", 16'h0000, {15'h0, busy_n});
        check("hold", 16'h0001, {15'h0, sample_hold});
        check("oe", 16'h0000, {8'h00, parallel_data_oe});
    endtask : start
    task automatic finish();
        int n = 0;
        chip_select_n <= 1'h1;
        read_convert  <= 1'h1;
        while (busy_n !== 1'h1 && n < 600) begin
            @(posedge clock);
            n++;
        end
        check("busy_n high", 16'h0001, {15'h0, busy_n});
        check("hold", 16'h0000, {15'h0, sample_hold});
        last = result_format_select ? sample_code : sample_code ^ 16'h8000;
    endtask : finish
    task automatic read_bytes(logic [15:0] exp);
        chip_select_n <= 1'h0;
        for (int b = 0; b < 2; b++) begin
            byte_select <= b[0];
            repeat (6) @(posedge clock);
            check("byte", {8'h00, b ? exp[7:0] : exp[15:8]}, {8'h00, parallel_data_out});
            check("oe", 16'h00ff, {8'h00, parallel_data_oe});
        end
        chip_select_n <= 1'h1;
        repeat (6) @(posedge clock);
        check("oe", 16'h0000, {8'h00, parallel_data_oe});
    endtask : read_bytes
    // ---------
    // scenarios
    // ---------
    task automatic t_parallel();
        for (int f = 0; f < 2; f++) begin
            result_format_select <= f[0];
            sample_code          <= f ? 16'h5a3c : 16'hc3a5;
            start(1'h0);
            finish();
            read_bytes(last);
        end
        $display("parallel test done");
    endtask : t_parallel
    task automatic t_ignore();
        sample_code <= 16'ha5c3;
        start(1'h0);
        chip_select_n <= 1'h1;
        repeat (3) @(posedge clock);
        chip_select_n <= 1'h0;
        repeat (14) @(posedge clock);
        finish();
        repeat (30) @(posedge clock);
        check("busy_n idle", 16'h0001, {15'h0, busy_n});
        read_bytes(last);
        $display("ignore test done");
    endtask : t_ignore
    task automatic t_serial(logic ext);
        logic [15:0] w;
        logic [15:0] prev;
        prev = last;
        clock_source_select <= ext;
        sample_code         <= ext ? 16'h6e19 : 16'hb00d;
        repeat (4) @(posedge clock);
        check("clk oe", {15'h0, !ext}, {15'h0, serial_shift_clock_oe});
        fork
            start(!ext);
            for (int i = 0; i < 16 && !ext; i++) begin
                @(posedge shift_wire);
                w = {w[14:0], serial_result_out};
            end
        join
        finish();
        if (ext) begin
            u_host.read_frame(w);
        end
        check("serial word", ext ? last : prev, w);
        // no new word: second frame returns the tag bits, alternating from 0
        if (ext) begin
            u_host.read_frame(w);
            check("tag word", 16'h5555, w);
        end
        $display("serial test done");
    endtask : t_serial
    task automatic t_shutdown();
        analog_shutdown    <= 1'h1;
        reference_shutdown <= 1'h1;
        sample_code        <= 16'h0ff0;
        repeat (6) @(posedge clock);
        check("power", 16'h0000, {14'h0, analog_power_on, reference_enable});
        start(1'h0);
        finish();
        read_bytes(last);
        analog_shutdown    <= 1'h0;
        reference_shutdown <= 1'h0;
        repeat (6) @(posedge clock);
        check("power", 16'h0003, {14'h0, analog_power_on, reference_enable});
        $display("shutdown test done");
    endtask : t_shutdown
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // ----
    // runs
    // ----
    initial begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end
    initial begin
        {arst_n, byte_select, analog_shutdown, reference_shutdown} = 4'h0;
        {chip_select_n, read_convert, result_format_select, clock_source_select} = 4'hf;
        sample_code = 16'h0000;
        last = 16'h0000;
        repeat (8) @(posedge clock);
        arst_n <= 1'h1;
        repeat (3) @(posedge clock);
        t_parallel();
        t_ignore();
        t_serial(1'h0);
        t_serial(1'h1);
        t_shutdown();
        wrap_up();
    end
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
endmodule : sar_adc_host_interface_tb_top
